// ---- logic/pdt_consts.vh ----
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define PDT_IDX_MISC           8'h17
`define PDT_IDX_CABLE_AB       8'h18
`define PDT_IDX_CABLE_CD       8'h19
`define PDT_IDX_CABLE_TERM     8'h1A
`define PDT_IDX_GEN_CTRL       8'h1D

// Miscellaneous register fields
`define PDT_MISC_PORT_HI       15
`define PDT_MISC_PORT_LO       11
`define PDT_MISC_PD_EN         10
`define PDT_MISC_PD_ST_HI      9
`define PDT_MISC_PD_ST_LO      8
`define PDT_CRC_MAX            8'hFF
`define PDT_CRC_ZERO           8'h00

// Cable test register fields
`define PDT_CT_TRIG            15
`define PDT_CT_VALID           14

// Generator control fields and reset value (destination nibble resets to 0001)
`define PDT_GEN_EN             15
`define PDT_GEN_RUN            14
`define PDT_GEN_CONT           13
`define PDT_GEN_LEN_HI         12
`define PDT_GEN_LEN_LO         11
`define PDT_GEN_GAP            10
`define PDT_GEN_DA_HI          9
`define PDT_GEN_DA_LO          6
`define PDT_GEN_SA_HI          5
`define PDT_GEN_SA_LO          2
`define PDT_GEN_RAND           1
`define PDT_GEN_BADFCS         0
`define PDT_GEN_RESET          16'h0040

// Frame lengths in bytes, FCS included
`define PDT_LEN_125            14'd125
`define PDT_LEN_64             14'd64
`define PDT_LEN_1518           14'd1518
`define PDT_LEN_JUMBO          10000
`define PDT_HDR_BYTES          14'd12
`define PDT_FCS_BYTES          14'd4
`define PDT_ADDR_HI_BYTE       8'hFF

// Frame counts
`define PDT_BURST_FRAMES       30000000
`define PDT_BLOCK_FRAMES       10000

// Timing: clock period and inter-frame gaps, least times round up
`define PDT_CLK_NS             40
`define PDT_GAP_SHORT_NS       96
`define PDT_GAP_LONG_NS        8192
`define PDT_GAP_SHORT_CYC      ((`PDT_GAP_SHORT_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_GAP_LONG_CYC       ((`PDT_GAP_LONG_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)

// Frame check sequence, reflected polynomial
`define PDT_CRC_POLY           32'hEDB88320
`define PDT_CRC_INIT           32'hFFFFFFFF
`define PDT_LFSR_SEED          16'hACE1

`endif

// ---- logic/pdt_top.v ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"

module pdt_top #(
  parameter        ADDR_W       = 8,
  parameter        BURST_FRAMES = `PDT_BURST_FRAMES,
  parameter        BLOCK_FRAMES = `PDT_BLOCK_FRAMES,
  parameter        JUMBO_LEN    = `PDT_LEN_JUMBO,
  parameter [7:0]  FIXED_BYTE   = 8'hAA
) (
  // Clock and reset
  input  wire              clk,
  input  wire              reset_n,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Port address strap
  input  wire [4:0]        port_addr_strap,
  // Inline power detection
  output reg               pd_enable,
  input  wire [1:0]        pd_status_in,
  // Receive path bad-CRC event, one pulse per frame
  input  wire              rx_crc_err,
  // Cable measurement engine
  output reg               cable_test_start,
  input  wire              cable_test_done,
  input  wire [5:0]        cable_dist_a,
  input  wire [5:0]        cable_dist_b,
  input  wire [5:0]        cable_dist_c,
  input  wire [5:0]        cable_dist_d,
  input  wire [3:0]        cable_term_a,
  input  wire [3:0]        cable_term_b,
  input  wire [3:0]        cable_term_c,
  input  wire [3:0]        cable_term_d,
  // Generated frame byte stream
  output reg  [7:0]        tx_data,
  output reg               tx_en,
  output reg               gen_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_FRAME = 2'd1;
  localparam [1:0] ST_GAP   = 2'd2;
  // Gap lengths in whole cycles, rounded up so a gap is never shorter than
  // the programmed time; the long gap still fits the 8-bit gap counter
  localparam integer GAP_SHORT_I = `PDT_GAP_SHORT_CYC;
  localparam integer GAP_LONG_I  = `PDT_GAP_LONG_CYC;
  localparam [7:0]   GAP_SHORT   = GAP_SHORT_I[7:0];
  localparam [7:0]   GAP_LONG    = GAP_LONG_I[7:0];

  reg  [4:0]  port_addr;        // Latched strap value
  reg         port_caught;      // Strap already taken since reset
  reg  [7:0]  crc_cnt;          // Bad-CRC frame count
  reg         ct_trig;          // Test in progress
  reg         ct_valid;         // Results valid
  reg  [5:0]  dist_a;           // Distances, three metres per count
  reg  [5:0]  dist_b;
  reg  [5:0]  dist_c;
  reg  [5:0]  dist_d;
  reg  [15:0] term_codes;       // A in 15:12 down to D in 3:0
  reg  [15:0] gen_ctrl;         // Software view of generator control
  reg  [15:0] gen_snap;         // Settings frozen at run start
  reg         go_q;             // Previous enable-and-run level
  reg  [1:0]  state;            // Generator state
  reg  [13:0] byte_idx;         // Byte position in frame
  reg  [13:0] frame_len;        // Frozen frame length
  reg  [7:0]  gap_cnt;          // Remaining gap cycles
  reg  [24:0] frame_cnt;        // Frames sent since run start
  reg  [13:0] block_cnt;        // Frames within current block
  reg  [31:0] crc;              // Running frame check value
  reg  [15:0] lfsr;             // Random payload source
  reg  [7:0]  next_byte;        // Byte chosen for this cycle
  reg  [31:0] next_rdata;       // Read mux result
  reg         next_err;         // Unmapped address

  wire [ADDR_W-1:0] word_idx = paddr >> 2;
  wire        acc_done  = psel & penable & pready;
  wire        wr_done   = acc_done & pwrite & ~pslverr;
  wire        rd_done   = acc_done & ~pwrite & ~pslverr;
  wire        go        = gen_ctrl[`PDT_GEN_EN] & gen_ctrl[`PDT_GEN_RUN];
  wire [13:0] pay_end   = frame_len - `PDT_FCS_BYTES;
  wire        last_byte = (byte_idx == frame_len - 14'd1);

  // One byte of the reflected CRC-32 update
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0]  d;
    integer      k;
    reg   [31:0] r;
    begin
      r = c ^ {24'h000000, d};
      for (k = 0; k < 8; k = k + 1) begin
        r = r[0] ? ((r >> 1) ^ `PDT_CRC_POLY) : (r >> 1);
      end
      crc_step = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and read mux
  always @* begin
    next_err   = 1'b0;
    next_rdata = 32'h00000000;
    case (word_idx)
      `PDT_IDX_MISC: begin
        // Status reads zero while detection is off
        next_rdata = {16'h0000, port_addr, pd_enable,
                      (pd_enable ? pd_status_in : 2'b00), crc_cnt};
      end
      `PDT_IDX_CABLE_AB: begin
        next_rdata = {16'h0000, ct_trig, ct_valid, dist_a, 2'b00, dist_b};
      end
      `PDT_IDX_CABLE_CD: begin
        next_rdata = {16'h0000, 2'b00, dist_c, 2'b00, dist_d};
      end
      `PDT_IDX_CABLE_TERM: begin
        next_rdata = {16'h0000, term_codes};
      end
      `PDT_IDX_GEN_CTRL: begin
        next_rdata = {16'h0000, gen_ctrl};
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, data and error registered with pready
  // The access phase always sees pready low first, so every transfer takes
  // exactly one wait state; writes and read-clears act while pready is high
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_err;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port address strap taken on the first edge after reset release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_addr   <= 5'h00;
      port_caught <= 1'b0;
    end else if (!port_caught) begin
      port_addr   <= port_addr_strap;
      port_caught <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power detection enable and bad-CRC counter
  // Saturation keeps a flood of bad frames from wrapping to a small count
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_enable <= 1'b0;
      crc_cnt   <= `PDT_CRC_ZERO;
    end else begin
      if (wr_done && word_idx == `PDT_IDX_MISC) begin
        pd_enable <= pwdata[`PDT_MISC_PD_EN];
      end
      // An error landing on the clearing read is kept as the first count
      if (rd_done && word_idx == `PDT_IDX_MISC) begin
        crc_cnt <= rx_crc_err ? 8'h01 : `PDT_CRC_ZERO;
      end else if (rx_crc_err && crc_cnt != `PDT_CRC_MAX) begin
        crc_cnt <= crc_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cable test trigger, completion and result capture
  // A done pulse outside a running test is ignored, so stale results stay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ct_trig          <= 1'b0;
      ct_valid         <= 1'b0;
      cable_test_start <= 1'b0;
      dist_a           <= 6'h00;
      dist_b           <= 6'h00;
      dist_c           <= 6'h00;
      dist_d           <= 6'h00;
      term_codes       <= 16'h0000;
    end else begin
      cable_test_start <= 1'b0;
      if (!ct_trig && wr_done && word_idx == `PDT_IDX_CABLE_AB && pwdata[`PDT_CT_TRIG]) begin
        // Writes while a test runs are ignored; old distances and codes stay until the done capture below
        ct_trig          <= 1'b1;
        ct_valid         <= 1'b0;
        cable_test_start <= 1'b1;
      end else if (ct_trig && cable_test_done) begin
        ct_trig    <= 1'b0;
        ct_valid   <= 1'b1;
        dist_a     <= cable_dist_a;
        dist_b     <= cable_dist_b;
        dist_c     <= cable_dist_c;
        dist_d     <= cable_dist_d;
        // Codes pass through unchanged: 0000 good, 0001 open, 0010 short,
        // 0100 abnormal, 10xx short to pair, 11xx coupling with pair
        term_codes <= {cable_term_a, cable_term_b, cable_term_c, cable_term_d};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator control register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_ctrl <= `PDT_GEN_RESET;
    end else if (wr_done && word_idx == `PDT_IDX_GEN_CTRL) begin
      gen_ctrl <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte selection for the current frame position
  // Bytes 0 to 11 are addresses; the check value covers header and payload
  always @* begin
    next_byte = 8'h00;
    if (byte_idx < 14'd5 || (byte_idx >= 14'd6 && byte_idx < 14'd11)) begin
      next_byte = `PDT_ADDR_HI_BYTE;
    end else if (byte_idx == 14'd5) begin
      next_byte = {4'hF, gen_snap[`PDT_GEN_DA_HI:`PDT_GEN_DA_LO]};
    end else if (byte_idx == 14'd11) begin
      next_byte = {4'hF, gen_snap[`PDT_GEN_SA_HI:`PDT_GEN_SA_LO]};
    end else if (byte_idx < pay_end) begin
      next_byte = gen_snap[`PDT_GEN_RAND] ? lfsr[7:0] : FIXED_BYTE;
    end else begin
      // Inverted check value sent low byte first; bad mode flips it again
      case (byte_idx - pay_end)
        14'd0:   next_byte = ~crc[7:0];
        14'd1:   next_byte = ~crc[15:8];
        14'd2:   next_byte = ~crc[23:16];
        default: next_byte = ~crc[31:24];
      endcase
      if (gen_snap[`PDT_GEN_BADFCS]) begin
        next_byte = ~next_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator sequencer: frame, gap, frame and block counting
  // The burst counter is wide enough for the full burst length; burst and
  // block ends are only looked at in the gap, never in the middle of a frame
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      go_q      <= 1'b0;
      gen_snap  <= `PDT_GEN_RESET;
      byte_idx  <= 14'd0;
      frame_len <= `PDT_LEN_125;
      gap_cnt   <= 8'h00;
      frame_cnt <= 25'd0;
      block_cnt <= 14'd0;
      crc       <= `PDT_CRC_INIT;
      lfsr      <= `PDT_LFSR_SEED;
      tx_data   <= 8'h00;
      tx_en     <= 1'b0;
      gen_busy  <= 1'b0;
    end else begin
      go_q  <= go;
      tx_en <= 1'b0;
      case (state)
        ST_IDLE: begin
          gen_busy <= 1'b0;
          // Only a fresh rise of enable-and-run starts and freezes settings
          if (go && !go_q) begin
            gen_snap  <= gen_ctrl;
            case (gen_ctrl[`PDT_GEN_LEN_HI:`PDT_GEN_LEN_LO])
              2'b00:   frame_len <= `PDT_LEN_125;
              2'b01:   frame_len <= `PDT_LEN_64;
              2'b10:   frame_len <= `PDT_LEN_1518;
              default: frame_len <= JUMBO_LEN[13:0];
            endcase
            byte_idx  <= 14'd0;
            frame_cnt <= 25'd0;
            block_cnt <= 14'd0;
            crc       <= `PDT_CRC_INIT;
            gen_busy  <= 1'b1;
            state     <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          tx_en   <= 1'b1;
          tx_data <= next_byte;
          if (byte_idx < pay_end) begin
            crc <= crc_step(crc, next_byte);
          end
          if (byte_idx >= `PDT_HDR_BYTES && byte_idx < pay_end && gen_snap[`PDT_GEN_RAND]) begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
          end
          byte_idx <= byte_idx + 14'd1;
          if (last_byte) begin
            byte_idx  <= 14'd0;
            crc       <= `PDT_CRC_INIT;
            frame_cnt <= frame_cnt + 25'd1;
            gap_cnt   <= gen_snap[`PDT_GEN_GAP] ? GAP_LONG : GAP_SHORT;
            state     <= ST_GAP;
            if (block_cnt == BLOCK_FRAMES[13:0] - 14'd1) begin
              block_cnt <= 14'd0;
            end else begin
              block_cnt <= block_cnt + 14'd1;
            end
          end
        end
        ST_GAP: begin
          gap_cnt <= gap_cnt - 8'h01;
          if (gap_cnt == 8'h01) begin
            // Clearing enable or run stops at the end of the gap that follows the current frame
            if (!go) begin
              state <= ST_IDLE;
            end else if (!gen_snap[`PDT_GEN_CONT] && frame_cnt == BURST_FRAMES[24:0]) begin
              state <= ST_IDLE;
            end else if (gen_snap[`PDT_GEN_CONT] && !gen_ctrl[`PDT_GEN_CONT] && block_cnt == 14'd0) begin
              // Live bit watched here so software can end a continuous run
              state <= ST_IDLE;
            end else begin
              state <= ST_FRAME;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pdt_top

`default_nettype wire

// ---- verif/pdt_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Cable measurement engine seen from the block
module pdt_far_model #(
  parameter int DELAY = 20
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cable_test_start,
  input  wire logic [23:0] res_dist,           // Distances A,B,C,D
  input  wire logic [15:0] res_term,           // Codes A,B,C,D
  output var  logic        cable_test_done,
  output wire logic [23:0] dist_bus,
  output wire logic [15:0] term_bus
);
  int cnt;                                     // Cycles left in the test
  // Done pulses once, DELAY cycles after start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      cable_test_done <= 1'b0;
    end else begin
      cable_test_done <= (cnt == 1);
      if (cable_test_start) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // Results are only good with done; inverse elsewhere exposes a late latch
  assign dist_bus = cable_test_done ? res_dist : ~res_dist;
  assign term_bus = cable_test_done ? res_term : ~res_term;
endmodule // pdt_far_model
`default_nettype wire

// ---- verif/pdt_props.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Port-level checks on the diagnostic block
module pdt_props #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Side outputs
  input wire logic              pd_enable,
  input wire logic              cable_test_start,
  input wire logic              cable_test_done,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_en,
  input wire logic              gen_busy
);
  logic ct_run;                               // Cable test in flight
  wire  acc = psel && penable && pready;      // Completing transfer
  // Track the test between start and done so a refused trigger is not flagged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ct_run <= 1'b0;
    else if (cable_test_start) ct_run <= 1'b1;
    else if (cable_test_done) ct_run <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one wait state");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_trig_start: assert property (acc && pwrite && paddr == 8'h60 && pwdata[15] && !ct_run |=>
    cable_test_start) else $error("trigger gave no start");
  a_start_pulse: assert property (cable_test_start |=> !cable_test_start) else $error("start too long");
  a_pd_write: assert property (acc && pwrite && paddr == 8'h5C && pwdata[10] |=> pd_enable)
    else $error("detect enable not set");
  a_frame_gap: assert property ($fell(tx_en) |-> !tx_en [*3]) else $error("gap too short");
  a_tx_busy: assert property (tx_en |-> gen_busy) else $error("tx while idle");
  a_da_first: assert property ($rose(tx_en) |-> tx_data == 8'hFF) else $error("frame head wrong");
  c_frame: cover property ($rose(tx_en));
  c_cable: cover property (cable_test_done && ct_run);
  c_err: cover property (pslverr);
endmodule // pdt_props

bind pdt_top pdt_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pd_enable(pd_enable), .cable_test_start(cable_test_start),
  .cable_test_done(cable_test_done), .tx_data(tx_data), .tx_en(tx_en), .gen_busy(gen_busy));
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
////////////////////////////////////////////////////////////
module testbench;
  localparam logic [7:0] A_MISC = `PDT_IDX_MISC << 2;
  localparam logic [7:0] A_AB   = `PDT_IDX_CABLE_AB << 2;
  localparam logic [7:0] A_CD   = `PDT_IDX_CABLE_CD << 2;
  localparam logic [7:0] A_TERM = `PDT_IDX_CABLE_TERM << 2;
  localparam logic [7:0] A_GEN  = `PDT_IDX_GEN_CTRL << 2;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err, rx_crc_err;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  strap;
  logic [1:0]  pd_st;
  logic        pd_enable, start, done, tx_en, gen_busy, was_en;
  logic [23:0] rdist, dbus;
  logic [15:0] rterm, tbus;
  int          n_errors, total_checks, nfr, gap, last_gap;
  logic [7:0]  cap[$];                          // Captured frame bytes
  pdt_top #(.BURST_FRAMES(2), .BLOCK_FRAMES(2), .JUMBO_LEN(100), .FIXED_BYTE(8'hAA)) DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_addr_strap(strap),
    .pd_enable(pd_enable), .pd_status_in(pd_st), .rx_crc_err(rx_crc_err), .cable_test_start(start),
    .cable_test_done(done), .cable_dist_a(dbus[23:18]), .cable_dist_b(dbus[17:12]),
    .cable_dist_c(dbus[11:6]), .cable_dist_d(dbus[5:0]), .cable_term_a(tbus[15:12]),
    .cable_term_b(tbus[11:8]), .cable_term_c(tbus[7:4]), .cable_term_d(tbus[3:0]),
    .tx_data(tx_data), .tx_en(tx_en), .gen_busy(gen_busy));
  pdt_far_model u_far (.clk(clk), .reset_n(reset_n), .cable_test_start(start), .res_dist(rdist),
    .res_term(rterm), .cable_test_done(done), .dist_bus(dbus), .term_bus(tbus));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Frame monitor: bytes, frame count and last gap length
  always @(posedge clk) begin
    if (tx_en) begin
      cap.push_back(tx_data);
      if (!was_en) begin
        nfr++;
        last_gap = gap;
      end
      gap = 0;
    end else gap++;
    was_en = tx_en;
  end
  // One bus transfer; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) n_errors++;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string n);
    apb(1'b0, a, 16'h0000);
    `CHK(n, {16'h0000, e}, rd)
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      rx_crc_err <= 1'b1;
      @(posedge clk);
      rx_crc_err <= 1'b0;
    end
  endtask
  // Waits for the generator to start, then for it to return idle
  task automatic wait_idle;
    int k;
    k = 0;
    while (gen_busy !== 1'b1 && k < 10) begin
      @(posedge clk);
      k++;
    end
    if (k >= 10) n_errors++;
    k = 0;
    while (gen_busy !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) n_errors++;
  endtask
  // Check value of the first n captured bytes, as sent low byte first
  function automatic logic [31:0] fcs_calc(input int n);
    logic [31:0] c;
    c = `PDT_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h000000, cap[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ `PDT_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(A_MISC, {strap, 11'h000}, "misc");
    rchk(A_AB, 16'h0000, "ab");
    rchk(A_CD, 16'h0000, "cd");
    rchk(A_TERM, 16'h0000, "term");
    rchk(A_GEN, 16'h0040, "gen");
    apb(1'b0, 8'h00, 16'h0000);
    `CHK("unmapped", 1'b1, err)
    $display("test reset done");
  endtask
  task automatic t_crc;
    pulses(3);
    rchk(A_MISC, {strap, 11'h003}, "crc3");
    rchk(A_MISC, {strap, 11'h000}, "crc clr");
    pulses(300);
    rchk(A_MISC, {strap, 11'h0FF}, "crc sat");
    pulses(2);
    rchk(A_MISC, {strap, 11'h002}, "crc rst");
    $display("test crc done");
  endtask
  task automatic t_pd;
    apb(1'b1, A_MISC, 16'h0400);
    for (int s = 0; s < 3; s++) begin
      pd_st <= s[1:0];
      rchk(A_MISC, {strap, 1'b1, s[1:0], 8'h00}, "pd st");
    end
    `CHK("pd_en", 1'b1, pd_enable)
    apb(1'b1, A_MISC, 16'h0000);
    rchk(A_MISC, {strap, 11'h000}, "pd off");
    $display("test detect done");
  endtask
  task automatic t_cable;
    logic [15:0] tv [3] = '{16'h0124, 16'h89AB, 16'hCDEF};
    logic [15:0] ab;
    int k;
    ab = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      rdist = 24'hAB3C5D + 24'(i * 24'h041041);
      rterm = tv[i];
      apb(1'b1, A_AB, 16'h8000);
      rchk(A_AB, {2'b10, ab[13:0]}, "trig");
      k = 0;
      do begin
        apb(1'b0, A_AB, 16'h0000);
        k++;
      end while (rd[15] && k < 100);
      ab = {2'b01, rdist[23:18], 2'b00, rdist[17:12]};
      `CHK("ab", {16'h0000, ab}, rd)
      rchk(A_CD, {2'b00, rdist[11:6], 2'b00, rdist[5:0]}, "cd");
      rchk(A_TERM, rterm, "term");
    end
    $display("test cable done");
  endtask
  task automatic t_gen;
    int k;
    apb(1'b1, A_GEN, 16'hC968);
    wait_idle();
    `CHK("frames", 2, nfr)
    `CHK("bytes", 128, cap.size())
    `CHK("gap", `PDT_GAP_SHORT_CYC, last_gap)
    `CHK("da", 48'hFFFFFFFFFFF5, {cap[0], cap[1], cap[2], cap[3], cap[4], cap[5]})
    `CHK("sa", 48'hFFFFFFFFFFFA, {cap[6], cap[7], cap[8], cap[9], cap[10], cap[11]})
    `CHK("payload", 8'hAA, cap[12])
    `CHK("fcs good", fcs_calc(60), {cap[63], cap[62], cap[61], cap[60]})
    apb(1'b1, A_GEN, 16'h8968);
    cap.delete();
    nfr = 0;
    apb(1'b1, A_GEN, 16'hE443);
    k = 0;
    while (nfr < 3 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    apb(1'b1, A_GEN, 16'hC843);
    wait_idle();
    `CHK("blk frames", 4, nfr)
    `CHK("blk bytes", 500, cap.size())
    `CHK("long gap", `PDT_GAP_LONG_CYC, last_gap)
    `CHK("da2", 8'hF1, cap[5])
    `CHK("fcs bad", ~fcs_calc(121), {cap[124], cap[123], cap[122], cap[121]})
    `CHK("rand", 1'b0, cap[12] == 8'hAA && cap[13] == 8'hAA)
    $display("test generator done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, rx_crc_err, was_en} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 5'h15;
    pd_st = 2'b01;
    rdist = 24'h0;
    rterm = 16'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_crc();
    t_pd();
    t_cable();
    t_gen();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
